/* File: src/cif_defs.svh */
// Card interface constants: register offsets, field positions, reset values
`ifndef CIF_DEFS_SVH
`define CIF_DEFS_SVH
`define CIF_OFF_CTRL 12'h000
`define CIF_OFF_STAT 12'h004
`define CIF_OFF_MASK 12'h008
`define CIF_OFF_TXD 12'h00c
`define CIF_OFF_RXD 12'h010
`define CIF_CTRL_RUN 29
`define CIF_CTRL_DIV2 28
`define CIF_CTRL_ETU_HI 24
`define CIF_CTRL_ETU_LO 8
`define CIF_CTRL_INV 7
`define CIF_CTRL_RXRT 6
`define CIF_CTRL_TXRT 5
`define CIF_CTRL_IDLE 4
`define CIF_CTRL_CLKON 3
`define CIF_CTRL_RSTPOL 2
`define CIF_CTRL_V3 1
`define CIF_CTRL_EN 0
`define CIF_CTRL_MASK 32'h31ffffff
`define CIF_CTRL_RESET 32'h00000000
`define CIF_ST_TXEMPTY 4
`define CIF_ST_RXFULL 3
`define CIF_ST_OVERRUN 2
`define CIF_ST_RXFAIL 1
`define CIF_ST_TXFAIL 0
`define CIF_MASK_RESET 8'h00
`define CIF_RETRIES 3
`endif

/* File: src/cif_pkg.sv */
// Card interface types
package cif_pkg;
  typedef enum logic [2:0] {
    CIF_IDLE = 3'b000,
    CIF_TX = 3'b001,
    CIF_TXGUARD = 3'b010,
    CIF_RXWAIT = 3'b011,
    CIF_RX = 3'b100,
    CIF_RXGUARD = 3'b101
  } cif_state_e;
  typedef logic [7:0] cif_byte_t;
endpackage

/* File: src/cif_bus_if.sv */
// Byte hand-off between the register front end and the serial engine
`timescale 1ns/1ps
`default_nettype none
interface cif_bus_if;
  logic txValid;
  logic [7:0] txByte;
  logic txTake;
  logic rxPut;
  logic [7:0] rxByte;
  logic rxFail;
  logic txFail;
  logic busy;
  logic dirWrite;
  modport regs (output txValid, output txByte, input txTake, input rxPut, input rxByte,
    input rxFail, input txFail, input busy, input dirWrite);
  modport eng (input txValid, input txByte, output txTake, output rxPut, output rxByte,
    output rxFail, output txFail, output busy, output dirWrite);
endinterface
`default_nettype wire

/* File: src/cif_serial_engine.sv */
// Character engine: sends and receives framed characters, one line bit per elementary time unit
`timescale 1ns/1ps
`default_nettype none
`include "cif_defs.svh"
module cif_serial_engine
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic runEn,
  input wire logic etuTick,
  input wire logic inverseConv,
  input wire logic txRetryEn,
  input wire logic rxRetryEn,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  cif_bus_if.eng bus
);
  import cif_pkg::*;
  typedef struct packed {
    cif_state_e st;
    logic [3:0] bitCnt;
    logic [9:0] shift;
    logic [1:0] tries;
    logic parityErr;
    logic oe;
    logic out;
    logic take;
    logic put;
    logic rxF;
    logic txF;
    logic [7:0] rxB;
  } cif_eng_s;
  cif_eng_s s_reg, s_next;
  function automatic logic [7:0] conv(input logic [7:0] b, input logic inv);
    logic [7:0] r;
    r = b;
    if (inv)
    begin
      for (int i = 0; i < 8; i++)
        r[i] = ~b[7 - i];
    end
    return r;
  endfunction
  always_comb
  begin
    logic [7:0] cb;
    cb = conv(bus.txByte, inverseConv);
    s_next = s_reg;
    s_next.take = 1'b0;
    s_next.put = 1'b0;
    s_next.rxF = 1'b0;
    s_next.txF = 1'b0;
    if (!runEn)
    begin
      s_next.st = CIF_IDLE;
      s_next.oe = 1'b0;
      s_next.out = 1'b1;
      s_next.tries = 2'd0;
    end
    else if (etuTick)
    begin
      unique case (s_reg.st)
        CIF_IDLE:
        begin
          if (bus.txValid)
          begin
            s_next.shift = {^cb ^ inverseConv, cb, 1'b0};
            s_next.bitCnt = 4'd0;
            s_next.st = CIF_TX;
            s_next.oe = 1'b1;
            // Start bit is low in both conventions
            s_next.out = 1'b0;
          end
          else if (!dataIn)
          begin
            s_next.st = CIF_RX;
            s_next.bitCnt = 4'd0;
          end
        end
        CIF_TX:
        begin
          s_next.bitCnt = s_reg.bitCnt + 4'd1;
          if (s_reg.bitCnt == 4'd9)
          begin
            s_next.oe = 1'b0;
            s_next.st = CIF_TXGUARD;
          end
          else
            s_next.out = s_reg.shift[s_reg.bitCnt + 4'd1];
        end
        CIF_TXGUARD:
        begin
          s_next.st = CIF_IDLE;
          if (!dataIn && txRetryEn && s_reg.tries != 2'(`CIF_RETRIES))
            s_next.tries = s_reg.tries + 2'd1;
          else
          begin
            s_next.take = 1'b1;
            s_next.txF = !dataIn;
            s_next.tries = 2'd0;
          end
        end
        CIF_RX:
        begin
          // Raw line levels are kept; conversion happens once, on hand-off
          s_next.shift = {dataIn, s_reg.shift[9:1]};
          s_next.bitCnt = s_reg.bitCnt + 4'd1;
          if (s_reg.bitCnt == 4'd8)
          begin
            // Nine line bits carry an even count of ones in direct, odd in inverse convention
            s_next.parityErr = ^{dataIn, s_reg.shift[9:2]} != inverseConv;
            s_next.st = CIF_RXGUARD;
            if (^{dataIn, s_reg.shift[9:2]} != inverseConv && rxRetryEn
                && s_reg.tries != 2'(`CIF_RETRIES))
            begin
              s_next.oe = 1'b1;
              s_next.out = 1'b0;
            end
          end
        end
        CIF_RXGUARD:
        begin
          s_next.oe = 1'b0;
          s_next.out = 1'b1;
          s_next.st = CIF_IDLE;
          if (s_reg.oe)
            s_next.tries = s_reg.tries + 2'd1;
          else
          begin
            s_next.tries = 2'd0;
            s_next.rxB = conv(s_reg.shift[8:1], inverseConv);
            s_next.put = !s_reg.parityErr;
            s_next.rxF = s_reg.parityErr;
          end
        end
        default:
          s_next.st = CIF_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '{st: CIF_IDLE, out: 1'b1, default: '0};
    else
      s_reg <= s_next;
  end
  assign dataOut = s_reg.out;
  assign dataOe = s_reg.oe;
  assign bus.txTake = s_reg.take;
  assign bus.rxPut = s_reg.put;
  assign bus.rxByte = s_reg.rxB;
  assign bus.rxFail = s_reg.rxF;
  assign bus.txFail = s_reg.txF;
  assign bus.busy = (s_reg.st != CIF_IDLE);
  // Error signalling on receive drives the line too, so the translator must point outward
  assign bus.dirWrite = (s_reg.st == CIF_TX) || (s_reg.st == CIF_TXGUARD) || s_reg.oe;
endmodule
`default_nettype wire

/* File: src/card_if.sv */
// Card interface top: APB registers, clock and time unit dividers, pins, activity interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cif_defs.svh"
module cif_card_if
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_data_in,
  output logic card_data_out,
  output logic card_data_oe,
  output logic card_clock_out,
  output logic card_reset_out,
  output logic card_supply_enable,
  output logic translator_direction,
  output logic card_voltage_select,
  output logic timerClockTick,
  output logic etuClockTick,
  output logic activityIrq
);
  import cif_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] mask;
    logic [4:0] stat;
    logic [7:0] txHold;
    logic txFull;
    logic [7:0] rxHold;
    logic rxFull;
    logic clkDiv;
    logic [16:0] etuCnt;
    logic cardClk;
    logic [31:0] rdata;
    logic resetLvl;
    logic rdDone;
  } cif_top_s;
  cif_top_s s_reg, s_next;
  cif_bus_if bus();
  logic wrEn, rdEn, runEn, clkEdge, etuTick;
  logic [7:0] statByte;
  logic [31:0] ctrlEff;
  assign wrEn = psel && penable && pwrite;
  // Reads take one wait state so registered read data stands while pready is high
  assign rdEn = psel && penable && !pwrite && !s_reg.rdDone;
  assign runEn = s_reg.ctrl[`CIF_CTRL_RUN] && s_reg.ctrl[`CIF_CTRL_EN];
  // Soft reset: pins and dividers see the default word, the written word stays readable
  assign ctrlEff = s_reg.ctrl[`CIF_CTRL_RUN] ? s_reg.ctrl : `CIF_CTRL_RESET;
  assign clkEdge = ctrlEff[`CIF_CTRL_CLKON] && (!ctrlEff[`CIF_CTRL_DIV2] || s_reg.clkDiv);
  // Time unit counts card clock periods, two clkEdge pulses each
  assign etuTick = clkEdge && s_reg.cardClk && (s_reg.etuCnt == 17'h0);
  assign statByte = {3'h0, s_reg.stat};
  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = 32'h0;
    s_next.rdDone = rdEn;
    if (ctrlEff[`CIF_CTRL_CLKON])
    begin
      s_next.clkDiv = ~s_reg.clkDiv;
      if (clkEdge)
      begin
        s_next.cardClk = ~s_reg.cardClk;
        if (s_reg.cardClk)
          s_next.etuCnt = (s_reg.etuCnt == 17'h0) ? ctrlEff[`CIF_CTRL_ETU_HI:`CIF_CTRL_ETU_LO]
            : s_reg.etuCnt - 17'h1;
      end
    end
    else
      s_next.cardClk = ctrlEff[`CIF_CTRL_IDLE];
    s_next.resetLvl = ctrlEff[`CIF_CTRL_RSTPOL];
    if (bus.txTake)
      s_next.txFull = 1'b0;
    if (bus.rxFail)
      s_next.stat[`CIF_ST_RXFAIL] = 1'b1;
    if (bus.txFail)
      s_next.stat[`CIF_ST_TXFAIL] = 1'b1;
    if (rdEn)
    begin
      unique case (paddr)
        `CIF_OFF_CTRL: s_next.rdata = s_reg.ctrl;
        `CIF_OFF_STAT:
        begin
          s_next.rdata = {24'h0, statByte};
          // Reading clears error flags; an error landing in the same cycle survives
          s_next.stat[2:0] = {1'b0, bus.rxFail, bus.txFail};
        end
        `CIF_OFF_MASK: s_next.rdata = {24'h0, s_reg.mask};
        `CIF_OFF_RXD:
        begin
          s_next.rdata = {24'h0, s_reg.rxHold};
          s_next.rxFull = 1'b0;
        end
        default: s_next.rdata = 32'h0;
      endcase
    end
    if (wrEn)
    begin
      unique case (paddr)
        `CIF_OFF_CTRL: s_next.ctrl = pwdata & `CIF_CTRL_MASK;
        `CIF_OFF_MASK: s_next.mask = {3'h0, pwdata[4:0]};
        `CIF_OFF_TXD:
        begin
          if (!s_reg.txFull || bus.txTake)
          begin
            s_next.txHold = pwdata[7:0];
            s_next.txFull = 1'b1;
          end
        end
        default: s_next.ctrl = s_next.ctrl;
      endcase
    end
    if (bus.rxPut)
    begin
      if (s_next.rxFull)
        s_next.stat[`CIF_ST_OVERRUN] = 1'b1;
      else
      begin
        s_next.rxHold = bus.rxByte;
        s_next.rxFull = 1'b1;
      end
    end
    s_next.stat[`CIF_ST_TXEMPTY] = !s_next.txFull;
    s_next.stat[`CIF_ST_RXFULL] = s_next.rxFull;
    if (!s_reg.ctrl[`CIF_CTRL_RUN])
    begin
      // Soft reset holds mask, status, buffer flags and time unit count at default; the control word and hold bytes keep theirs
      s_next.mask = `CIF_MASK_RESET;
      s_next.stat = 5'h10;
      s_next.txFull = 1'b0;
      s_next.rxFull = 1'b0;
      s_next.etuCnt = 17'h0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '{stat: 5'h10, ctrl: `CIF_CTRL_RESET, default: '0};
    else
      s_reg <= s_next;
  end
  cif_serial_engine u_eng
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .runEn(runEn),
    .etuTick(etuTick),
    .inverseConv(s_reg.ctrl[`CIF_CTRL_INV]),
    .txRetryEn(s_reg.ctrl[`CIF_CTRL_TXRT]),
    .rxRetryEn(s_reg.ctrl[`CIF_CTRL_RXRT]),
    .dataIn(card_data_in),
    .dataOut(card_data_out),
    .dataOe(card_data_oe),
    .bus(bus.eng)
  );
  assign bus.txValid = s_reg.txFull;
  assign bus.txByte = s_reg.txHold;
  assign prdata = s_reg.rdata;
  assign pready = pwrite || s_reg.rdDone;
  assign pslverr = 1'b0;
  assign card_clock_out = s_reg.cardClk;
  // Reset asserted while the interface is off; released when enabled
  assign card_reset_out = runEn ? ~s_reg.resetLvl : s_reg.resetLvl;
  assign card_supply_enable = runEn;
  assign translator_direction = bus.dirWrite;
  assign card_voltage_select = ctrlEff[`CIF_CTRL_V3];
  // Time-out counting lives in the external timer; these feed it
  assign timerClockTick = clkEdge && s_reg.cardClk;
  assign etuClockTick = etuTick;
  assign activityIrq = |(statByte & s_reg.mask);
endmodule
`default_nettype wire

/* File: testbench/cif_card_if_properties.sv */
// Port checker for the card interface top
`timescale 1ns/1ps
`default_nettype none
`include "cif_defs.svh"
module cif_card_if_properties
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic card_data_oe,
  input wire logic card_clock_out,
  input wire logic card_reset_out,
  input wire logic card_supply_enable,
  input wire logic translator_direction,
  input wire logic card_voltage_select,
  input wire logic activityIrq
);
  logic [31:0] ctrlShadow;
  logic [7:0] maskShadow;
  logic [1:0] ctrlAge;
  logic acc;
  logic settled;
  assign acc = psel && penable && pready;
  // Pins get three cycles of slack after a control write
  assign settled = ctrlAge == 2'h3 && ctrlShadow[29];
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrlShadow <= 32'h00000000;
      maskShadow <= 8'h00;
      ctrlAge <= 2'h0;
    end
    else
    begin
      ctrlAge <= (ctrlAge == 2'h3) ? ctrlAge : ctrlAge + 2'h1;
      if (acc && pwrite && paddr == `CIF_OFF_CTRL)
      begin
        ctrlShadow <= pwdata & `CIF_CTRL_MASK;
        ctrlAge <= 2'h0;
      end
      if (acc && pwrite && paddr == `CIF_OFF_MASK)
        maskShadow <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence statRead;
    acc && !pwrite && paddr == `CIF_OFF_STAT;
  endsequence
  sequence ctrlRead;
    acc && !pwrite && paddr == `CIF_OFF_CTRL;
  endsequence
  chk_irq_masked: assert property (maskShadow == 8'h00 && $past(maskShadow) == 8'h00 |-> !activityIrq)
    else $error("activity irq with every source masked");
  chk_soft_reset: assert property (ctrlAge == 2'h3 && !ctrlShadow[29] |-> !activityIrq && !card_supply_enable)
    else $error("outputs active while held in soft reset");
  chk_stat_width: assert property (statRead |-> prdata[31:5] == 27'h0)
    else $error("status read shows bits above its width");
  chk_ctrl_reserved: assert property (ctrlRead |-> prdata[31:30] == 2'h0 && prdata[27:25] == 3'h0)
    else $error("control reserved bits read nonzero");
  chk_volt_select: assert property (settled |-> card_voltage_select == ctrlShadow[1])
    else $error("voltage select differs from control");
  chk_supply_on: assert property (settled |-> card_supply_enable == ctrlShadow[0])
    else $error("supply enable differs from control");
  chk_reset_level: assert property (settled |-> card_reset_out == (ctrlShadow[2] ^ ctrlShadow[0]))
    else $error("card reset level wrong");
  chk_clock_idle: assert property (settled && !ctrlShadow[3] |-> card_clock_out == ctrlShadow[4])
    else $error("stopped card clock at wrong level");
  chk_half_duplex: assert property (card_data_oe |-> translator_direction || $past(translator_direction))
    else $error("data driven while translator set to read");
endmodule
`default_nettype wire

/* File: testbench/cif_card_model.sv */
// Behavioural card: frames bytes to and from the device data line
`timescale 1ns/1ps
`default_nettype none
module cif_card_model
(
  input wire logic core_clk,
  input wire logic etuClockTick,
  input wire logic card_data_out,
  input wire logic card_data_oe,
  output logic cardLine
);
  logic cardDrv = 1'b0;
  logic cardBit = 1'b1;
  logic [8:0] sh;
  logic [8:0] frames [4];
  int etuLen = 0;
  int cnt = 0;
  int nRx = 0;
  // Pull-up holds the line high when nobody drives it
  assign cardLine = card_data_oe ? card_data_out : (cardDrv ? cardBit : 1'b1);
  always @(posedge core_clk)
  begin
    cnt <= cnt + 1;
    if (etuClockTick)
    begin
      etuLen <= cnt + 1;
      cnt <= 0;
    end
  end
  // Start bit, eight bits lowest first, even parity, then line released
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {^b, b, 1'b0};
    wait (etuLen > 0);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      cardDrv <= 1'b1;
      cardBit <= f[i];
      repeat (etuLen - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    cardDrv <= 1'b0;
    repeat (2 * etuLen) @(posedge core_clk);
  endtask
  // Samples mid-bit so a registered edge on the line never lands on a sample
  initial
  forever
  begin
    @(posedge core_clk);
    if (card_data_oe && !card_data_out)
    begin
      repeat (etuLen / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (etuLen) @(posedge core_clk);
        sh = {cardLine, sh[8:1]};
      end
      frames[nRx % 4] = sh;
      nRx++;
      repeat (etuLen) @(posedge core_clk);
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Top bench: register tests over APB and card traffic through the card model
`timescale 1ns/1ps
`default_nettype none
`include "cif_defs.svh"
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, cardLine, card_data_out, card_data_oe, card_clock_out, card_reset_out;
  logic card_supply_enable, translator_direction, card_voltage_select, timerClockTick, etuClockTick, activityIrq;
  logic err;
  int nFail = 0;
  int comparisons = 0;
  int nTick = 0;
  int nEtu = 0;
  // Run, time unit of four card periods for short frames, clock on, enabled
  localparam logic [31:0] RUN = 32'h20000309;
  cif_card_if DUT (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .card_data_in(cardLine), .card_data_out, .card_data_oe, .card_clock_out, .card_reset_out, .card_supply_enable,
    .translator_direction, .card_voltage_select, .timerClockTick, .etuClockTick, .activityIrq);
  cif_card_model card (.core_clk, .etuClockTick, .card_data_out, .card_data_oe, .cardLine);
  initial
  forever #12.5 core_clk = ~core_clk;
  task automatic wrap_up();
    if (nFail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk32(what, {31'h0, exp}, {31'h0, got});
  endtask
  // Request holds until pready is seen high; read data and error are taken at that same edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(what, exp, rd);
    chk1("slave error", 1'b0, err);
  endtask
  task automatic waitStat(input int b);
    do apb(1'b0, `CIF_OFF_STAT, 32'h0); while (rd[b] !== 1'b1);
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    rdk("ctrl reset", `CIF_OFF_CTRL, 32'h0);
    rdk("status reset", `CIF_OFF_STAT, 32'h10);
    rdk("mask reset", `CIF_OFF_MASK, 32'h0);
    rdk("unmapped", 12'h014, 32'h0);
    apb(1'b1, `CIF_OFF_CTRL, 32'hffffffff);
    rdk("ctrl bits", `CIF_OFF_CTRL, `CIF_CTRL_MASK);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, `CIF_OFF_CTRL, 32'h20000000 | {27'h0, i[3], 1'b0, i[2:0]});
      repeat (4) @(posedge core_clk);
      chk1("supply", i[0], card_supply_enable);
      chk1("voltage", i[1], card_voltage_select);
      chk1("card reset", i[2] ^ i[0], card_reset_out);
      chk1("clock idle", i[3], card_clock_out);
    end
    apb(1'b1, `CIF_OFF_CTRL, 32'h0000000b);
    repeat (4) @(posedge core_clk);
    chk1("held supply", 1'b0, card_supply_enable);
    chk1("held voltage", 1'b0, card_voltage_select);
    // Port C pin selects are set by software before this; the bench stands in for it
    apb(1'b1, `CIF_OFF_CTRL, RUN);
    apb(1'b1, `CIF_OFF_MASK, 32'h10);
    repeat (2) @(posedge core_clk);
    chk1("irq tx empty", 1'b1, activityIrq);
    apb(1'b1, `CIF_OFF_TXD, 32'ha5);
    waitStat(`CIF_ST_TXEMPTY);
    apb(1'b1, `CIF_OFF_TXD, 32'ha7);
    rdk("tx pending", `CIF_OFF_STAT, 32'h0);
    wait (card.nRx == 2);
    chk32("frame one", {23'h0, ^8'ha5, 8'ha5}, {23'h0, card.frames[0]});
    chk32("frame two", {23'h0, ^8'ha7, 8'ha7}, {23'h0, card.frames[1]});
    waitStat(`CIF_ST_TXEMPTY);
    apb(1'b1, `CIF_OFF_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk1("irq masked", 1'b0, activityIrq);
    apb(1'b1, `CIF_OFF_MASK, 32'h08);
    card.sendByte(8'h5a);
    waitStat(`CIF_ST_RXFULL);
    chk1("irq rx full", 1'b1, activityIrq);
    rdk("rx byte", `CIF_OFF_RXD, 32'h5a);
    rdk("rx drained", `CIF_OFF_STAT, 32'h10);
    apb(1'b1, `CIF_OFF_MASK, 32'h04);
    card.sendByte(8'h11);
    card.sendByte(8'h22);
    chk1("irq overrun", 1'b1, activityIrq);
    rdk("overrun", `CIF_OFF_STAT, 32'h1c);
    rdk("overrun cleared", `CIF_OFF_STAT, 32'h18);
    chk1("irq after clear", 1'b0, activityIrq);
    // Inverse convention: 0x01 goes most significant bit first with inverted levels, parity level 0
    apb(1'b1, `CIF_OFF_CTRL, 32'h20000389);
    apb(1'b1, `CIF_OFF_TXD, 32'h01);
    wait (card.nRx == 3);
    chk32("inverse frame", {23'h0, 1'b0, 8'h7f}, {23'h0, card.frames[2]});
    waitStat(`CIF_ST_TXEMPTY);
    // All-low character has even parity, which inverse convention refuses
    card.sendByte(8'h00);
    rdk("rx parity fail", `CIF_OFF_STAT, 32'h1a);
    // Halved card clock: period of four cycles, time unit of four card periods
    apb(1'b1, `CIF_OFF_CTRL, 32'h30000309);
    repeat (20) @(posedge core_clk);
    repeat (32)
    begin
      @(posedge core_clk);
      nTick += timerClockTick;
      nEtu += etuClockTick;
    end
    chk32("card clock periods", 32'd8, nTick);
    chk32("time units", 32'd2, nEtu);
    wrap_up();
  end
  initial
  begin
    repeat (50000) @(posedge core_clk);
    nFail++;
    wrap_up();
  end
endmodule
bind cif_card_if cif_card_if_properties chk (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .card_data_oe, .card_clock_out, .card_reset_out, .card_supply_enable, .translator_direction,
  .card_voltage_select, .activityIrq);
`default_nettype wire
